/* File: charger_thermal_supervisor.sv */
/*
  Thermal supervisor of a d.c. charger with an actively cooled cable.
  Watches both contact sensors and the coolant loop, runs the session
  precheck, shuts down on faults, derates on cooling loss and keeps the
  service lockout. Assumes session_start, session_end and the limit
  settings come from the charging controller on the same clock, and
  that sensor and coolant status arrive from pins.

  Timing: a contact pin reaches the verdict registers three clocks
  later. A latched contact fault forces shutdown_req so that the whole
  path from pin to output fits inside SHUTDOWN_CYCLES, whether or not the
  fault clears in the meantime. Cooling loss acts one clock after its
  second sync stage. Limitation: a contact fault never shuts down early,
  so the controller must start its own ramp as soon as shutdown_req rises.
  Outputs: supply_enable and shutdown_req decode the state, derate_active
  ORs cool_derate and plaus_fail, the others are registers; derate_report pulses once per cooling-derated session.
  The service lockout survives idle time and new sessions; only the
  synchronised service_clear releases it. The overtemperature count also
  clears when a session ends without an overtemperature shutdown.
  A failed precheck keeps the uncooled current offered until service, or zero when no uncooled limit is given.

  // Function
  // - Keep each contact assembly at or below 90 degC while operating.
  // - Judge the positive and negative contact sensors separately.
  // - Supervise coolant flow, pressure, temperature and level for a first fault.
  // - On cooling failure stop, or derate to the uncooled limit if given.
  // - Report the reduced available current to the vehicle after cooling derate.
  // - Sample and judge contact temperatures every clock through the whole session.
  // - Contact above 90 degC starts error shutdown within 9 s.
  // - Third consecutive overtemperature shutdown blocks supply until serviced.
  // - Check sensor plausibility before every session, before supply starts.
  // - Failed precheck limits output to the uncooled cable current.
  // - Failed precheck latches a lockout until the charger is serviced.
  // - Missing or implausible sensor signal while charging: shutdown within 9 s.
*/
`timescale 1ns/1ps
`default_nettype none
module charger_thermal_supervisor #(
  parameter logic [31:0] SHUTDOWN_CYCLES = thermal_pkg::SHUTDOWN_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [11:0] temp_pos_raw,
  input wire logic temp_pos_present,
  input wire logic [11:0] temp_neg_raw,
  input wire logic temp_neg_present,
  input wire logic coolant_flow_ok,
  input wire logic coolant_pressure_ok,
  input wire logic coolant_temp_ok,
  input wire logic coolant_level_ok,
  input wire logic service_clear,
  input wire logic session_start,
  input wire logic session_end,
  input wire logic uncooled_limit_given,
  input wire logic [15:0] uncooled_limit,
  input wire logic [15:0] rated_limit,
  output logic supply_enable,
  output logic shutdown_req,
  output logic [1:0] shutdown_cause,
  output logic service_lockout,
  output logic derate_active,
  output logic [15:0] available_current,
  output logic derate_report
);

  // Whole supervisor state in one record: pin_s1/pin_s2 are the two
  // sync stages of the service and coolant pins (bit 4 is service),
  // fault_pend with pend_cause is the latched contact fault whose
  // deadline is running, cause is what the last shutdown reported,
  // ot_count counts overtemperature shutdowns in a row, ot_session marks
  // a session that ended in one, and avail is the offered current.
  typedef struct packed {
    thermal_pkg::sup_state_t fsm;
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic fault_pend;
    thermal_pkg::cause_t pend_cause;
    thermal_pkg::cause_t cause;
    logic [1:0] ot_count;
    logic ot_session;
    logic lockout;
    logic plaus_fail;
    logic cool_derate;
    logic report;
    logic [15:0] avail;
  } sup_t;

  sup_t st_reg;
  sup_t st_next;

  // Channel verdicts, each already through its own sync stages
  logic [11:0] pos_code;
  logic [11:0] neg_code;
  logic pos_valid;
  logic neg_valid;
  logic pos_over;
  logic neg_over;
  logic expired;

  // Absolute difference of two temperature codes
  function automatic logic [11:0] temp_diff(input logic [11:0] a,
                                            input logic [11:0] b);
    temp_diff = (a > b) ? (a - b) : (b - a);
  endfunction

  // Smaller of two currents; the offer never exceeds the rating
  function automatic logic [15:0] cur_min(input logic [15:0] a,
                                          input logic [15:0] b);
    cur_min = (a < b) ? a : b;
  endfunction

  // Each contact has its own channel and its own verdict
  sensor_channel pos_chan (
    .clk(clk),
    .sys_rst(sys_rst),
    .temp_raw(temp_pos_raw),
    .temp_present(temp_pos_present),
    .temp_code(pos_code),
    .temp_valid(pos_valid),
    .temp_over(pos_over)
  );

  // Same channel for the negative contact, with no logic shared
  sensor_channel neg_chan (
    .clk(clk),
    .sys_rst(sys_rst),
    .temp_raw(temp_neg_raw),
    .temp_present(temp_neg_present),
    .temp_code(neg_code),
    .temp_valid(neg_valid),
    .temp_over(neg_over)
  );

  // Runs from the first fault seen until shutdown is forced
  // The pin path latency is taken off, so the deadline holds from the pin
  deadline_timer #(
    .COUNT(SHUTDOWN_CYCLES - thermal_pkg::FAULT_PATH_CYCLES)
  ) fault_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(st_reg.fault_pend),
    .expired(expired)
  );

  // Combined verdicts; coolant bits are read only after the second stage
  logic cool_fault;
  logic sens_fault;
  logic over_temp;
  logic plaus_ok;
  logic [15:0] cur_cap;

  // Verdicts are plain gates of registered values, one clock old at most
  always_comb begin
    cur_cap = cur_min(uncooled_limit, rated_limit);
    cool_fault = ~&st_reg.pin_s2[3:0];
    sens_fault = ~pos_valid | ~neg_valid;
    over_temp = pos_over | neg_over;
    plaus_ok = pos_valid && neg_valid &&
               (temp_diff(pos_code, neg_code) <= thermal_pkg::PLAUS_DIFF_CODE);
  end

  // Supervisor state machine and latched flags
  always_comb begin
    st_next = st_reg;
    // Two sync stages for every pin that crosses into this clock
    st_next.pin_s1 = {service_clear, coolant_level_ok, coolant_temp_ok,
                      coolant_pressure_ok, coolant_flow_ok};
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.report = 1'b0;

    // Service releases lockout and history; a set below still wins
    if (st_reg.pin_s2[4]) begin
      st_next.lockout = 1'b0;
      st_next.ot_count = 2'h0;
      st_next.plaus_fail = 1'b0;
    end

    // IDLE waits for a start, PRECHECK judges both sensors for one
    // clock, CHARGING grants supply and watches every fault, SHUTDOWN
    // holds the error request until the controller closes the session.
    // A start is refused while locked; nothing shows the refusal except
    // supply_enable staying low.
    case (st_reg.fsm)
      thermal_pkg::ST_IDLE: begin
        // Idle drops any pending fault left by a session cut short
        st_next.fault_pend = 1'b0;
        st_next.pend_cause = thermal_pkg::CAUSE_NONE;
        st_next.cool_derate = 1'b0;
        // A locked charger refuses every new supply process
        if (session_start && !st_next.lockout) begin
          st_next.fsm = thermal_pkg::ST_PRECHECK;
          st_next.cause = thermal_pkg::CAUSE_NONE;
          st_next.ot_session = 1'b0;
        end
      end
      thermal_pkg::ST_PRECHECK: begin
        // Supply is granted only after both sensors look sane
        if (plaus_ok) begin
          st_next.fsm = thermal_pkg::ST_CHARGING;
        end else begin
          // A failed check leaves this session without supply
          st_next.plaus_fail = 1'b1;
          st_next.lockout = 1'b1;
          st_next.fsm = thermal_pkg::ST_IDLE;
        end
      end
      thermal_pkg::ST_CHARGING: begin
        // Latch the first fault so a flickering sensor cannot restart
        // the deadline; the shutdown comes at expiry at the latest
        if (!st_reg.fault_pend && (over_temp || sens_fault)) begin
          st_next.fault_pend = 1'b1;
          st_next.pend_cause = over_temp ? thermal_pkg::CAUSE_OVERTEMP :
                                           thermal_pkg::CAUSE_SENSOR;
        end else if (st_reg.fault_pend && over_temp) begin
          st_next.pend_cause = thermal_pkg::CAUSE_OVERTEMP;
        end
        // Cooling loss: derate when the cable allows it, else stop
        // The report fires once, on the clock that first sets the derate
        if (cool_fault && !uncooled_limit_given) begin
          st_next.fsm = thermal_pkg::ST_SHUTDOWN;
          st_next.cause = thermal_pkg::CAUSE_COOLING;
          st_next.fault_pend = 1'b0;
        end else if (cool_fault && !st_reg.cool_derate) begin
          st_next.cool_derate = 1'b1;
          st_next.report = 1'b1;
        end
        // Deadline reached: the cause latched earlier is reported
        if (expired) begin
          st_next.fsm = thermal_pkg::ST_SHUTDOWN;
          st_next.cause = st_reg.pend_cause;
          st_next.fault_pend = 1'b0;
          if (st_reg.pend_cause == thermal_pkg::CAUSE_OVERTEMP) begin
            st_next.ot_session = 1'b1;
            // Saturate so the two-bit count never wraps back to zero
            if (st_next.ot_count < thermal_pkg::LOCKOUT_COUNT) begin
              st_next.ot_count = st_next.ot_count + 2'h1;
            end
            // The shutdown that brings the count to three locks at once
            if (st_next.ot_count >= thermal_pkg::LOCKOUT_COUNT) begin
              st_next.lockout = 1'b1;
            end
          end
        end else if (session_end) begin
          st_next.fsm = thermal_pkg::ST_IDLE;
          // A clean end clears the run of overtemperature shutdowns
          st_next.ot_count = 2'h0;
        end
      end
      thermal_pkg::ST_SHUTDOWN: begin
        // Held until the controller closes the session
        if (session_end) begin
          st_next.fsm = thermal_pkg::ST_IDLE;
          // Only a session that ended in overtemperature keeps its count
          if (!st_reg.ot_session) begin
            st_next.ot_count = 2'h0;
          end
        end
      end
      default: begin
        // An unknown state fails safe: supply off, error raised
        st_next.fsm = thermal_pkg::ST_SHUTDOWN;
      end
    endcase

    // Offered current follows the derate state
    // It is judged from the next state, so the cut lands together with
    // derate_active and never lags it by a clock
    if ((st_next.cool_derate || st_next.plaus_fail) && uncooled_limit_given) begin
      st_next.avail = cur_cap;
    end else if (st_next.plaus_fail) begin
      st_next.avail = 16'h0000;  // No uncooled figure: nothing is safe
    end else begin
      st_next.avail = rated_limit;
    end
  end

  // State register; reset leaves the supervisor idle with nothing latched
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // All outputs come straight from the state record
  // Supply and shutdown are decoded from the state, so they can never
  // both be high and change only on a state edge
  assign supply_enable = (st_reg.fsm == thermal_pkg::ST_CHARGING);
  assign shutdown_req = (st_reg.fsm == thermal_pkg::ST_SHUTDOWN);

  // Latched status for the charging controller
  assign shutdown_cause = st_reg.cause;
  assign service_lockout = st_reg.lockout;

  // Current offer and its report travel to the vehicle over the link
  assign derate_active = st_reg.cool_derate | st_reg.plaus_fail;
  assign available_current = st_reg.avail;
  assign derate_report = st_reg.report;

endmodule
`default_nettype wire

/* File: charger_thermal_supervisor_props.sv */
/* Port checker for the thermal supervisor, bound at the foot.
   Assumes static current limits and starts given only from idle. */
`timescale 1ns/1ps
`default_nettype none
module supervisor_props #(
  parameter logic [31:0] SHUTDOWN_CYCLES = 32'h0000_0010
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [11:0] temp_pos_raw,
  input wire logic temp_pos_present,
  input wire logic [11:0] temp_neg_raw,
  input wire logic temp_neg_present,
  input wire logic coolant_flow_ok,
  input wire logic service_clear,
  input wire logic session_start,
  input wire logic session_end,
  input wire logic uncooled_limit_given,
  input wire logic [15:0] uncooled_limit,
  input wire logic [15:0] rated_limit,
  input wire logic supply_enable,
  input wire logic shutdown_req,
  input wire logic [1:0] shutdown_cause,
  input wire logic service_lockout,
  input wire logic derate_active,
  input wire logic [15:0] available_current,
  input wire logic derate_report
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic pin_fault;
  logic [32:0] late_reg;
  logic [32:0] late_next;
  // Pin conditions that must end in a shutdown
  assign pin_fault = !temp_pos_present || !temp_neg_present
    || temp_pos_raw > thermal_pkg::TEMP_LIMIT_CODE || temp_pos_raw < thermal_pkg::PLAUS_MIN_CODE
    || temp_neg_raw > thermal_pkg::TEMP_LIMIT_CODE || temp_neg_raw < thermal_pkg::PLAUS_MIN_CODE
    || (!coolant_flow_ok && !uncooled_limit_given);
  // A counter, since the real deadline is far beyond any delay range
  assign late_next = (supply_enable && pin_fault) ? late_reg + 33'h1 : 33'h0;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      late_reg <= 33'h0;
    end else begin
      late_reg <= late_next;
    end
  end
  sequence s_start;
    session_start && !session_end && !service_lockout && !supply_enable && !shutdown_req
      && !$past(session_start) && !$past(session_start, 2);
  endsequence
  sequence s_cool_lost;
    (supply_enable && !coolant_flow_ok)[*2];
  endsequence
  property p_shut_off;
    shutdown_req |-> !supply_enable && shutdown_cause != 2'h0;
  endproperty
  property p_deadline;
    late_reg <= {1'b0, SHUTDOWN_CYCLES};
  endproperty
  property p_lock_blocks;
    service_lockout && !supply_enable |=> !supply_enable;
  endproperty
  property p_lock_holds;
    service_lockout && !service_clear && !$past(service_clear) && !$past(service_clear, 2)
      |=> service_lockout;
  endproperty
  property p_report;
    derate_report |-> derate_active ##1 !derate_report;
  endproperty
  property p_derate_cur;
    derate_active |-> available_current <= rated_limit
      && (!uncooled_limit_given || available_current <= uncooled_limit);
  endproperty
  property p_start;
    s_start |-> ##2 (supply_enable || service_lockout);
  endproperty
  property p_gate;
    $rose(supply_enable) |-> $past(session_start, 2);
  endproperty
  property p_cool;
    s_cool_lost |-> ##[1:4] (derate_active || shutdown_req || !supply_enable);
  endproperty
  a_shut_off: assert property (p_shut_off) else $error("supply during shutdown");
  a_deadline: assert property (p_deadline) else $error("shutdown late");
  a_lock_blocks: assert property (p_lock_blocks) else $error("supply when locked");
  a_lock_holds: assert property (p_lock_holds) else $error("lockout lost");
  a_report: assert property (p_report) else $error("bad derate report");
  a_derate_cur: assert property (p_derate_cur) else $error("derate too high");
  a_start: assert property (p_start) else $error("no precheck verdict");
  a_gate: assert property (p_gate) else $error("supply without start");
  a_cool: assert property (p_cool) else $error("cooling loss ignored");
endmodule
bind charger_thermal_supervisor supervisor_props #(.SHUTDOWN_CYCLES(SHUTDOWN_CYCLES))
  supervisor_props_inst (.clk, .sys_rst, .temp_pos_raw, .temp_pos_present, .temp_neg_raw,
  .temp_neg_present, .coolant_flow_ok, .service_clear, .session_start, .session_end,
  .uncooled_limit_given, .uncooled_limit, .rated_limit, .supply_enable, .shutdown_req,
  .shutdown_cause, .service_lockout, .derate_active, .available_current, .derate_report);
`default_nettype wire

/* File: charger_thermal_supervisor_test.sv */
/* Self-checking bench for the thermal supervisor.
   Assumes the package, design, model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module charger_thermal_supervisor_test;
  localparam logic [31:0] SC = 32'h0000_0014;
  localparam logic [11:0] NORMAL = 12'h2ee;
  localparam logic [11:0] HOT = 12'h579;
  localparam logic [15:0] UNC = 16'h0040;
  localparam logic [15:0] RATED = 16'h0100;
  logic clk, sys_rst, pos_open, neg_open, service_clear, session_start, session_end;
  logic uncooled_limit_given, temp_pos_present, temp_neg_present, supply_enable;
  logic shutdown_req, service_lockout, derate_active, derate_report;
  logic [11:0] pos_set, neg_set, temp_pos_raw, temp_neg_raw;
  logic [3:0] cool_ok;
  logic [1:0] shutdown_cause;
  logic [15:0] available_current;
  int errors, check_count, n;
  connector_model connector_model_inst (.clk, .pos_set, .neg_set, .pos_open, .neg_open,
    .temp_pos_raw, .temp_pos_present, .temp_neg_raw, .temp_neg_present);
  charger_thermal_supervisor #(.SHUTDOWN_CYCLES(SC)) charger_thermal_supervisor_inst (
    .clk, .sys_rst, .temp_pos_raw, .temp_pos_present, .temp_neg_raw, .temp_neg_present,
    .coolant_flow_ok(cool_ok[0]), .coolant_pressure_ok(cool_ok[1]),
    .coolant_temp_ok(cool_ok[2]), .coolant_level_ok(cool_ok[3]), .service_clear,
    .session_start, .session_end, .uncooled_limit_given, .uncooled_limit(UNC),
    .rated_limit(RATED), .supply_enable, .shutdown_req, .shutdown_cause, .service_lockout,
    .derate_active, .available_current, .derate_report);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic hang(input string what);
    errors++;
    $display("unexpected at %0t: %s", $time, what);
    final_report;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  // Sample 1 ns after the edge so its updates have landed
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic start;
    @(posedge clk) session_start <= 1'b1;
    @(posedge clk) session_start <= 1'b0;
    tick(2);
  endtask
  // Ending a session also restores healthy sensors and coolant
  task automatic stop;
    @(posedge clk);
    session_end <= 1'b1;
    pos_set <= NORMAL;
    neg_set <= NORMAL;
    pos_open <= 1'b0;
    neg_open <= 1'b0;
    cool_ok <= 4'hf;
    @(posedge clk) session_end <= 1'b0;
    tick(2);
  endtask
  task automatic wait_shut;
    n = 0;
    while (shutdown_req !== 1'b1 && n < SC + 20) begin
      tick(1);
      n++;
    end
    if (n >= SC + 20) hang("no shutdown");
  endtask
  task automatic hot_run(input bit neg);
    start;
    @(posedge clk);
    if (neg) neg_set <= HOT;
    else pos_set <= HOT;
    wait_shut;
    chk(16'(n >= SC - 6 && n <= SC), 16'h1, "deadline");
    chk(16'(shutdown_cause), 16'h1, "overtemp cause");
    stop;
  endtask
  // Exactly 90.0 degC is still allowed
  task automatic clean_run;
    start;
    chk(16'(supply_enable), 16'h1, "no supply");
    @(posedge clk) pos_set <= thermal_pkg::TEMP_LIMIT_CODE;
    tick(int'(SC) + 10);
    chk(16'(shutdown_req), 16'h0, "early shutdown");
    stop;
  endtask
  task automatic clear_service;
    @(posedge clk) service_clear <= 1'b1;
    @(posedge clk) service_clear <= 1'b0;
    tick(4);
    chk(16'(service_lockout), 16'h0, "lockout kept");
  endtask
  initial begin
    sys_rst = 1'b1;
    pos_set = NORMAL;
    neg_set = NORMAL;
    pos_open = 1'b0;
    neg_open = 1'b0;
    cool_ok = 4'hf;
    service_clear = 1'b0;
    session_start = 1'b0;
    session_end = 1'b0;
    uncooled_limit_given = 1'b1;
    errors = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    tick(5);
    chk(available_current, RATED, "idle current");
    // Two hot, one clean, three hot: only the third in a row locks
    for (int i = 0; i < 6; i++) begin
      if (i == 2) clean_run;
      else hot_run(i[0]);
      chk(16'(service_lockout), 16'(i == 5), "lockout count");
    end
    start;
    chk(16'(supply_enable), 16'h0, "locked start");
    clear_service;
    for (int j = 0; j < 2; j++) begin
      start;
      @(posedge clk);
      if (j == 0) pos_open <= 1'b1;
      else neg_open <= 1'b1;
      wait_shut;
      chk(16'(shutdown_cause), 16'h2, "sensor cause");
      stop;
    end
    @(posedge clk) pos_open <= 1'b1;
    tick(4);
    start;
    chk(16'({supply_enable, service_lockout, derate_active}), 16'h3, "precheck");
    chk(available_current, UNC, "precheck limit");
    @(posedge clk) pos_open <= 1'b0;
    clear_service;
    // Each coolant monitor; even ones with an uncooled limit given
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) uncooled_limit_given <= !k[0];
      start;
      @(posedge clk) cool_ok[k] <= 1'b0;
      n = 0;
      while (derate_report !== 1'b1 && shutdown_req !== 1'b1 && n < 8) begin
        tick(1);
        n++;
      end
      if (n == 8) hang("cooling loss ignored");
      if (k[0]) begin
        chk(16'(shutdown_cause), 16'h3, "cooling cause");
      end else begin
        chk(available_current, UNC, "derate current");
        tick(1);
        chk(16'({derate_report, derate_active}), 16'h1, "report pulse");
      end
      stop;
    end
    final_report;
  end
endmodule
`default_nettype wire

/* File: connector_model.sv */
/* Contact sensor pair seen from the supervisor's pins.
   Assumes the bench sets the temperatures and opens sensor paths. */
`timescale 1ns/1ps
`default_nettype none
module connector_model (
  input wire logic clk,
  input wire logic [11:0] pos_set,
  input wire logic [11:0] neg_set,
  input wire logic pos_open,
  input wire logic neg_open,
  output logic [11:0] temp_pos_raw,
  output logic temp_pos_present,
  output logic [11:0] temp_neg_raw,
  output logic temp_neg_present
);
  logic [11:0] junk_reg = 12'h000;
  // An open path reads as noise, never as the last good value
  always @(posedge clk) begin
    junk_reg <= junk_reg + 12'h5a5;
  end
  assign temp_pos_raw = pos_open ? junk_reg : pos_set;
  assign temp_pos_present = !pos_open;
  assign temp_neg_raw = neg_open ? ~junk_reg : neg_set;
  assign temp_neg_present = !neg_open;
endmodule
`default_nettype wire

/* File: deadline_timer.sv */
/*
  Deadline counter: counts system clocks while run is high and flags
  expiry after COUNT clocks. Dropping run clears it. Assumes run stays
  high from fault detection until the owner reacts to expiry.
*/
`timescale 1ns/1ps
`default_nettype none
module deadline_timer #(
  parameter logic [31:0] COUNT = 32'h0000_0010
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  output logic expired
);

  typedef struct packed {
    logic [31:0] cnt;
    logic done;
  } tmr_t;

  tmr_t st_reg;
  tmr_t st_next;

  // Saturate at the deadline so a late reaction never wraps around
  always_comb begin
    st_next = st_reg;
    if (!run) begin
      st_next = '0;
    end else if (st_reg.cnt >= COUNT - 32'h1) begin
      st_next.done = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 32'h1;
    end
  end

  // Counter register; reset and a dropped run both clear it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign expired = st_reg.done;

endmodule
`default_nettype wire

/* File: sensor_channel.sv */
/*
  One contact temperature channel: synchronises the sensor's presence
  flag and code, then judges presence, plausibility and overtemperature
  every clock. Assumes the sensor interface holds its code stable for
  several clocks around each update, so the word crosses cleanly.
*/
`timescale 1ns/1ps
`default_nettype none
module sensor_channel (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [11:0] temp_raw,
  input wire logic temp_present,
  output logic [11:0] temp_code,
  output logic temp_valid,
  output logic temp_over
);

  typedef struct packed {
    logic [12:0] s1;
    logic [12:0] s2;
    logic [11:0] code;
    logic valid;
    logic over;
  } chan_t;

  chan_t st_reg;
  chan_t st_next;

  // Judge only the second sync stage; stage one feeds stage two alone
  always_comb begin
    st_next = st_reg;
    st_next.s1 = {temp_present, temp_raw};
    st_next.s2 = st_reg.s1;
    st_next.code = st_reg.s2[11:0];
    st_next.valid = st_reg.s2[12] &&
                    (st_reg.s2[11:0] >= thermal_pkg::PLAUS_MIN_CODE) &&
                    (st_reg.s2[11:0] <= thermal_pkg::PLAUS_MAX_CODE);
    // Strictly above the limit counts as overtemperature
    st_next.over = st_reg.s2[12] &&
                   (st_reg.s2[11:0] > thermal_pkg::TEMP_LIMIT_CODE);
  end

  // Reset clears both stages, so no overtemperature verdict is raised before real data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign temp_code = st_reg.code;
  assign temp_valid = st_reg.valid;
  assign temp_over = st_reg.over;

endmodule
`default_nettype wire

/* File: thermal_pkg.sv */
/*
  Shared constants of the connector thermal supervisor: temperature code
  layout, thresholds, shutdown deadline, fault counting and state codes.
  Assumes a 250 MHz system clock and 12-bit temperature codes from the
  connector sensors in steps of 0.1 degC with a -50 degC origin.
*/
package thermal_pkg;

  // Temperature code: code = (degC + 50) * 10
  localparam int TEMP_W = 12;
  localparam logic [11:0] TEMP_LIMIT_CODE = 12'h578;  // 90.0 degC
  localparam logic [11:0] PLAUS_MIN_CODE = 12'h032;   // -45.0 degC
  localparam logic [11:0] PLAUS_MAX_CODE = 12'h7d0;   // 150.0 degC
  localparam logic [11:0] PLAUS_DIFF_CODE = 12'h0c8;  // 20.0 K apart

  // Deadline from fault detection to error shutdown
  localparam longint CLK_HZ = 250000000;
  localparam longint SHUTDOWN_DEADLINE_MS = 9000;
  localparam longint SHUTDOWN_CYCLES_L = (SHUTDOWN_DEADLINE_MS * CLK_HZ) / 1000;
  localparam logic [31:0] SHUTDOWN_CYCLES = SHUTDOWN_CYCLES_L[31:0];
  // Clocks from a contact pin to shutdown_req outside the timer: two sync
  // stages, the verdict, the fault latch and the state change
  localparam logic [31:0] FAULT_PATH_CYCLES = 32'h0000_0005;

  // Consecutive overtemperature shutdowns that lock the charger out
  localparam logic [1:0] LOCKOUT_COUNT = 2'h3;

  localparam int CUR_W = 16;

  typedef enum logic [1:0] {
    CAUSE_NONE = 2'b00,
    CAUSE_OVERTEMP = 2'b01,
    CAUSE_SENSOR = 2'b10,
    CAUSE_COOLING = 2'b11
  } cause_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRECHECK = 2'b01,
    ST_CHARGING = 2'b10,
    ST_SHUTDOWN = 2'b11
  } sup_state_t;

endpackage
